// >>> logic/bmw_window_regs.v
`timescale 1ns/1ps
`include "bmw_defs.vh"

module bmw_window_regs (
    // clock and reset
    input wire clk_sys,
    input wire arst_n,
    // configuration access, dword aligned, byte enables active low
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [7:0] cfg_addr,
    input wire [3:0] cfg_be_n,
    input wire [31:0] cfg_wdata,
    output reg [31:0] cfg_rdata_q,
    output reg cfg_rvalid_q,
    output reg cfg_hit_q,
    // transaction decode request
    input wire txn_valid,
    input wire txn_from_primary,
    input wire [3:0] txn_cmd,
    input wire [63:0] txn_addr,
    // forwarding decision
    output reg fwd_valid_q,
    output reg fwd_q,
    output reg fwd_mem_hit_q,
    output reg fwd_pf_hit_q
);
    // stored writable fields
    reg [11:0] mem_base_q;
    reg [11:0] mem_limit_q;
    reg [11:0] pf_base_q;
    reg [11:0] pf_limit_q;
    reg [7:0] pf_base_up_q [0:3];
    reg [7:0] pf_limit_up_q [0:3];

    wire [31:0] pf_base_up;
    wire [31:0] pf_limit_up;

    // dword decode
    wire [7:0] dw_addr;
    wire sel_mem;
    wire sel_pf;
    wire sel_base_up;
    wire sel_limit_up;
    wire sel_any;

    assign dw_addr = {cfg_addr[7:2], 2'b00};
    assign sel_mem = (dw_addr == `BMW_OFF_MEM_BASE);
    assign sel_pf = (dw_addr == `BMW_OFF_PF_BASE);
    assign sel_base_up = (dw_addr == `BMW_OFF_PF_BASE_UP);
    assign sel_limit_up = (dw_addr == `BMW_OFF_PF_LIMIT_UP);
    assign sel_any = sel_mem | sel_pf | sel_base_up | sel_limit_up;

    // lanes 0/1 hold the base half, lanes 2/3 the limit half
    wire wr_lo_nib;
    wire wr_lo_byte;
    wire wr_hi_nib;
    wire wr_hi_byte;

    assign wr_lo_nib = cfg_wr & ~cfg_be_n[0];
    assign wr_lo_byte = cfg_wr & ~cfg_be_n[1];
    assign wr_hi_nib = cfg_wr & ~cfg_be_n[2];
    assign wr_hi_byte = cfg_wr & ~cfg_be_n[3];

    // next values of the window fields; the read-only low nibble of each
    // half is never stored, so a stray write cannot disturb it
    reg [11:0] mem_base_d;
    reg [11:0] mem_limit_d;
    reg [11:0] pf_base_d;
    reg [11:0] pf_limit_d;

    always @* begin
        mem_base_d = mem_base_q;
        mem_limit_d = mem_limit_q;
        if (sel_mem) begin
            if (wr_lo_nib) begin
                mem_base_d[3:0] = cfg_wdata[7:4];
            end
            if (wr_lo_byte) begin
                mem_base_d[11:4] = cfg_wdata[15:8];
            end
            if (wr_hi_nib) begin
                mem_limit_d[3:0] = cfg_wdata[23:20];
            end
            if (wr_hi_byte) begin
                mem_limit_d[11:4] = cfg_wdata[31:24];
            end
        end
    end

    // memory window fields
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mem_base_q <= `BMW_FIELD_RST;
            mem_limit_q <= `BMW_FIELD_RST;
        end else begin
            mem_base_q <= mem_base_d;
            mem_limit_q <= mem_limit_d;
        end
    end

    always @* begin
        pf_base_d = pf_base_q;
        pf_limit_d = pf_limit_q;
        if (sel_pf) begin
            if (wr_lo_nib) begin
                pf_base_d[3:0] = cfg_wdata[7:4];
            end
            if (wr_lo_byte) begin
                pf_base_d[11:4] = cfg_wdata[15:8];
            end
            if (wr_hi_nib) begin
                pf_limit_d[3:0] = cfg_wdata[23:20];
            end
            if (wr_hi_byte) begin
                pf_limit_d[11:4] = cfg_wdata[31:24];
            end
        end
    end

    // prefetchable window fields
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pf_base_q <= `BMW_FIELD_RST;
            pf_limit_q <= `BMW_FIELD_RST;
        end else begin
            pf_base_q <= pf_base_d;
            pf_limit_q <= pf_limit_d;
        end
    end

    // upper 32 bits of the prefetchable boundaries, one flop bank per byte lane
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : g_up_lane
            reg [7:0] base_up_d;
            reg [7:0] limit_up_d;

            always @* begin
                base_up_d = pf_base_up_q[lane];
                limit_up_d = pf_limit_up_q[lane];
                if (cfg_wr && !cfg_be_n[lane]) begin
                    if (sel_base_up) begin
                        base_up_d = cfg_wdata[8*lane+7:8*lane];
                    end
                    if (sel_limit_up) begin
                        limit_up_d = cfg_wdata[8*lane+7:8*lane];
                    end
                end
            end

            always @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    pf_base_up_q[lane] <= `BMW_UP_RST;
                    pf_limit_up_q[lane] <= `BMW_UP_RST;
                end else begin
                    pf_base_up_q[lane] <= base_up_d;
                    pf_limit_up_q[lane] <= limit_up_d;
                end
            end
            assign pf_base_up[8*lane+7:8*lane] = pf_base_up_q[lane];
            assign pf_limit_up[8*lane+7:8*lane] = pf_limit_up_q[lane];
        end
    endgenerate

    // each 16-bit half with its read-only indicator nibble below the field
    wire [15:0] mem_base_rd;
    wire [15:0] mem_limit_rd;
    wire [15:0] pf_base_rd;
    wire [15:0] pf_limit_rd;

    assign mem_base_rd = {mem_base_q, `BMW_MEM_IND};
    assign mem_limit_rd = {mem_limit_q, `BMW_MEM_IND};
    assign pf_base_rd = {pf_base_q, `BMW_PF_IND};
    assign pf_limit_rd = {pf_limit_q, `BMW_PF_IND};

    // read mux; whole dword returned, the host masks unused lanes
    reg [31:0] rdata_d;

    always @* begin
        rdata_d = 32'h0000_0000;
        if (sel_mem) begin
            rdata_d = {mem_limit_rd, mem_base_rd};
        end else if (sel_pf) begin
            rdata_d = {pf_limit_rd, pf_base_rd};
        end else if (sel_base_up) begin
            rdata_d = pf_base_up;
        end else if (sel_limit_up) begin
            rdata_d = pf_limit_up;
        end
    end

    // answer next values; hit follows reads and writes, data only reads
    // so a write never disturbs data the host has yet to pick up
    reg cfg_rvalid_d;
    reg cfg_hit_d;
    reg [31:0] cfg_rdata_d;

    always @* begin
        cfg_rvalid_d = cfg_rd;
        cfg_hit_d = cfg_hit_q;
        cfg_rdata_d = cfg_rdata_q;
        if (cfg_rd) begin
            cfg_rdata_d = rdata_d;
            cfg_hit_d = sel_any;
        end else if (cfg_wr) begin
            cfg_hit_d = sel_any;
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cfg_rdata_q <= 32'h0000_0000;
            cfg_rvalid_q <= 1'b0;
            cfg_hit_q <= 1'b0;
        end else begin
            cfg_rdata_q <= cfg_rdata_d;
            cfg_rvalid_q <= cfg_rvalid_d;
            cfg_hit_q <= cfg_hit_d;
        end
    end

    // window compares
    wire mem_in_range;
    wire pf_in_range;
    wire addr_above_4g;

    // the non-prefetchable window only covers the low 4 GB
    assign addr_above_4g = |txn_addr[63:32];

    bmw_window_cmp #(
        .AW(32)
    ) u_mem_cmp (
        .addr(txn_addr[31:0]),
        .base_hi(mem_base_q),
        .limit_hi(mem_limit_q),
        .hit(mem_in_range)
    );

    bmw_window_cmp #(
        .AW(64)
    ) u_pf_cmp (
        .addr(txn_addr),
        .base_hi({pf_base_up, pf_base_q}),
        .limit_hi({pf_limit_up, pf_limit_q}),
        .hit(pf_in_range)
    );

    // command classes
    reg cmd_is_mem;

    always @* begin
        case (txn_cmd)
            `BMW_CMD_MEM_RD: cmd_is_mem = 1'b1;
            `BMW_CMD_MEM_WR: cmd_is_mem = 1'b1;
            `BMW_CMD_MEM_RD_MUL: cmd_is_mem = 1'b1;
            `BMW_CMD_MEM_RD_LINE: cmd_is_mem = 1'b1;
            `BMW_CMD_MEM_WR_INV: cmd_is_mem = 1'b1;
            default: cmd_is_mem = 1'b0;
        endcase
    end

    wire mem_hit_d;
    wire pf_hit_d;
    wire any_hit_d;
    wire fwd_d;

    assign mem_hit_d = cmd_is_mem & ~addr_above_4g & mem_in_range;
    assign pf_hit_d = cmd_is_mem & pf_in_range;
    assign any_hit_d = mem_hit_d | pf_hit_d;
    // downstream claims inside a window, upstream claims everything outside
    assign fwd_d = cmd_is_mem & (txn_from_primary ? any_hit_d : ~any_hit_d);

    // decision next values; results stand until the next request so a
    // slow consumer may still sample them after the valid pulse
    reg dec_valid_d;
    reg dec_fwd_d;
    reg dec_mem_hit_d;
    reg dec_pf_hit_d;

    always @* begin
        dec_valid_d = txn_valid;
        dec_fwd_d = fwd_q;
        dec_mem_hit_d = fwd_mem_hit_q;
        dec_pf_hit_d = fwd_pf_hit_q;
        if (txn_valid) begin
            dec_fwd_d = fwd_d;
            dec_mem_hit_d = mem_hit_d;
            dec_pf_hit_d = pf_hit_d;
        end
    end

    // one decision per request, one cycle later
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fwd_valid_q <= 1'b0;
            fwd_q <= 1'b0;
            fwd_mem_hit_q <= 1'b0;
            fwd_pf_hit_q <= 1'b0;
        end else begin
            fwd_valid_q <= dec_valid_d;
            fwd_q <= dec_fwd_d;
            fwd_mem_hit_q <= dec_mem_hit_d;
            fwd_pf_hit_q <= dec_pf_hit_d;
        end
    end
endmodule // bmw_window_regs

// >>> logic/bmw_defs.vh
// Behaviour
// - base/limit hold 12-bit field in bits 15:4
// - bottom boundary fills address bits 19:0 with zeros
// - top boundary fills address bits 19:0 with ones
// - windows are 1 MB aligned and sized
// - memory window low nibble reads zero, read-only
// - prefetch window low nibble reads one, read-only
// - memory window decides forwarding of memory transactions
// - prefetch window decides forwarding of memory reads/writes
// - prefetch bottom upper half from upper base register
// - prefetch top upper half from upper limit register
// - reset clears every writable base and limit field
// - upper base at 28h, upper limit at 2Ch
`ifndef BMW_DEFS_VH
`define BMW_DEFS_VH

// configuration byte offsets
`define BMW_OFF_MEM_BASE 8'h20
`define BMW_OFF_MEM_LIMIT 8'h22
`define BMW_OFF_PF_BASE 8'h24
`define BMW_OFF_PF_LIMIT 8'h26
`define BMW_OFF_PF_BASE_UP 8'h28
`define BMW_OFF_PF_LIMIT_UP 8'h2C

// field layout inside each 16-bit half
`define BMW_FIELD_LSB 4
`define BMW_FIELD_W 12
`define BMW_GRAN_BITS 20

// read-only low nibbles and fills
`define BMW_MEM_IND 4'h0
`define BMW_PF_IND 4'h1
`define BMW_FILL_BOTTOM 20'h00000
`define BMW_FILL_TOP 20'hFFFFF

// reset values
`define BMW_FIELD_RST 12'h000
`define BMW_UP_RST 8'h00

// bus command codes that carry memory traffic
`define BMW_CMD_MEM_RD 4'h6
`define BMW_CMD_MEM_WR 4'h7
`define BMW_CMD_MEM_RD_MUL 4'hC
`define BMW_CMD_MEM_RD_LINE 4'hE
`define BMW_CMD_MEM_WR_INV 4'hF

`endif

// >>> logic/bmw_window_cmp.v
`timescale 1ns/1ps
`include "bmw_defs.vh"

module bmw_window_cmp #(
    parameter AW = 64
) (
    // address under test
    input wire [AW-1:0] addr,
    // programmed boundary fields above the 1 MB granule
    input wire [AW-`BMW_GRAN_BITS-1:0] base_hi,
    input wire [AW-`BMW_GRAN_BITS-1:0] limit_hi,
    // result
    output wire hit
);
    wire [AW-1:0] bottom;
    wire [AW-1:0] top;

    assign bottom = {base_hi, `BMW_FILL_BOTTOM};
    assign top = {limit_hi, `BMW_FILL_TOP};
    // limit below base leaves no address satisfying both bounds
    assign hit = (addr >= bottom) && (addr <= top);
endmodule // bmw_window_cmp

// >>> tb/bmw_regs_asserts.sv
`timescale 1ns/1ps
module bmw_regs_asserts (
    // clock and reset
    input wire clk_sys,
    input wire arst_n,
    // config access
    input wire cfg_rd,
    input wire [7:0] cfg_addr,
    input wire [31:0] cfg_rdata_q,
    input wire cfg_rvalid_q,
    input wire cfg_hit_q,
    // decode
    input wire txn_valid,
    input wire txn_from_primary,
    input wire [3:0] txn_cmd,
    input wire [63:0] txn_addr,
    input wire fwd_valid_q,
    input wire fwd_q,
    input wire fwd_mem_hit_q,
    input wire fwd_pf_hit_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    wire mem_cmd = txn_cmd == 4'h6 || txn_cmd == 4'h7 || txn_cmd == 4'hC || txn_cmd >= 4'hE;
    wire [31:0] rd_q = cfg_rdata_q;
    sequence s_rd(a); cfg_rd && cfg_addr[7:2] == a; endsequence
    property p_rd_ans; cfg_rd |=> cfg_rvalid_q; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
    property p_rd_quiet; !cfg_rd |=> !cfg_rvalid_q; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read valid without read");
    property p_mem_nib; s_rd(6'h08) |=> cfg_hit_q && rd_q[3:0] == 4'h0 && rd_q[19:16] == 4'h0;
    endproperty
    a_mem_nib: assert property (p_mem_nib) else $error("memory window low nibble");
    property p_pf_nib; s_rd(6'h09) |=> cfg_hit_q && rd_q[3:0] == 4'h1 && rd_q[19:16] == 4'h1;
    endproperty
    a_pf_nib: assert property (p_pf_nib) else $error("prefetch window low nibble");
    property p_unmap; cfg_rd && cfg_addr[7:4] != 4'h2 |=> rd_q == 32'h0 && !cfg_hit_q; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_dec; txn_valid |=> fwd_valid_q; endproperty
    a_dec: assert property (p_dec) else $error("decode answer missing");
    property p_hold; !txn_valid |=> !fwd_valid_q && $stable(fwd_q); endproperty
    a_hold: assert property (p_hold) else $error("decision moved without request");
    property p_nonmem; txn_valid && !mem_cmd |=> !fwd_q && !fwd_mem_hit_q && !fwd_pf_hit_q;
    endproperty
    a_nonmem: assert property (p_nonmem) else $error("non-memory command decoded");
    property p_above4g; txn_valid && txn_addr[63:32] != 32'h0 |=> !fwd_mem_hit_q; endproperty
    a_above4g: assert property (p_above4g) else $error("memory window above 4 GB");
    property p_dir;
        txn_valid && mem_cmd |=> fwd_q == ($past(txn_from_primary) == (fwd_mem_hit_q || fwd_pf_hit_q));
    endproperty
    a_dir: assert property (p_dir) else $error("forward direction wrong");
endmodule // bmw_regs_asserts

// >>> tb/bmw_txn_src.sv
`timescale 1ns/1ps
module bmw_txn_src (
    // clock and command from bench
    input wire clk_sys,
    input wire go,
    input wire go_prim,
    input wire [3:0] go_cmd,
    input wire [63:0] go_addr,
    // decode request
    output reg txn_valid = 1'b0,
    output reg txn_from_primary = 1'b0,
    output reg [3:0] txn_cmd = 4'h0,
    output reg [63:0] txn_addr = 64'h0
);
    // idle lines toggle so a stale address never passes for a live one
    always @(posedge clk_sys) begin
        txn_valid <= go;
        txn_from_primary <= go ? go_prim : ~txn_from_primary;
        txn_cmd <= go ? go_cmd : ~txn_cmd;
        txn_addr <= go ? go_addr : ~txn_addr;
    end
endmodule // bmw_txn_src

// >>> tb/bmw_window_regs_tb_top.sv
`timescale 1ns/1ps
module bmw_window_regs_tb_top;
    reg clk_sys = 1'b0;
    reg arst_n = 1'b0;
    reg cfg_wr = 1'b0;
    reg cfg_rd = 1'b0;
    reg [7:0] cfg_addr = 8'h00;
    reg [3:0] cfg_be_n = 4'hF;
    reg [31:0] cfg_wdata = 32'h0;
    reg go = 1'b0;
    reg go_prim = 1'b0;
    reg [3:0] go_cmd = 4'h0;
    reg [63:0] go_addr = 64'h0;
    wire [31:0] cfg_rdata_q;
    wire cfg_rvalid_q, cfg_hit_q, txn_valid, txn_from_primary;
    wire [3:0] txn_cmd;
    wire [63:0] txn_addr;
    wire fwd_valid_q, fwd_q, fwd_mem_hit_q, fwd_pf_hit_q;
    integer n_errors = 0;
    integer comparisons = 0;
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    bmw_window_regs uut (.clk_sys(clk_sys), .arst_n(arst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_be_n(cfg_be_n), .cfg_wdata(cfg_wdata), .cfg_hit_q(cfg_hit_q),
        .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q), .txn_valid(txn_valid),
        .txn_from_primary(txn_from_primary), .txn_cmd(txn_cmd), .txn_addr(txn_addr),
        .fwd_valid_q(fwd_valid_q), .fwd_q(fwd_q), .fwd_mem_hit_q(fwd_mem_hit_q),
        .fwd_pf_hit_q(fwd_pf_hit_q));
    bmw_txn_src src (.clk_sys(clk_sys), .go(go), .go_prim(go_prim), .go_cmd(go_cmd),
        .go_addr(go_addr), .txn_valid(txn_valid), .txn_from_primary(txn_from_primary),
        .txn_cmd(txn_cmd), .txn_addr(txn_addr));
    task check(input [63:0] seen, input [63:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task wr(input [7:0] a, input [3:0] be, input [31:0] d);
        @(posedge clk_sys);
        cfg_wr <= 1'b1; cfg_addr <= a; cfg_be_n <= be; cfg_wdata <= d;
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
    endtask
    // answer latency is fixed at one edge, so no polling is needed
    task rd(input [7:0] a, input [31:0] e);
        @(posedge clk_sys);
        cfg_rd <= 1'b1; cfg_addr <= a;
        @(posedge clk_sys);
        cfg_rd <= 1'b0;
        #1 check({cfg_rvalid_q, cfg_hit_q, cfg_rdata_q}, {1'b1, a[7:4] == 4'h2, e});
    endtask
    task txn(input p, input [3:0] c, input [63:0] a, input [2:0] e);
        @(posedge clk_sys);
        go <= 1'b1; go_prim <= p; go_cmd <= c; go_addr <= a;
        @(posedge clk_sys);
        go <= 1'b0;
        @(posedge clk_sys);
        #1 check({fwd_valid_q, fwd_q, fwd_mem_hit_q, fwd_pf_hit_q}, {1'b1, e});
    endtask
    initial begin
        #100000 n_errors = n_errors + 1;
        wrap_up;
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(8'h20, 32'h0);
        rd(8'h24, 32'h00010001);
        rd(8'h28, 32'h0);
        rd(8'h2C, 32'h0);
        wr(8'h20, 4'h0, 32'hFFFFFFFF);
        rd(8'h20, 32'hFFF0FFF0);
        wr(8'h21, 4'hE, 32'h0);
        rd(8'h20, 32'hFFF0FF00);
        wr(8'h30, 4'h0, 32'hFFFFFFFF);
        #1 check(cfg_hit_q, 1'b0);
        rd(8'h30, 32'h0);
        wr(8'h20, 4'h0, 32'h00200010);
        #1 check(cfg_hit_q, 1'b1);
        wr(8'h24, 4'h0, 32'h10001000);
        wr(8'h28, 4'h0, 32'h1);
        wr(8'h2C, 4'h0, 32'h1);
        rd(8'h24, 32'h10011001);
        rd(8'h2C, 32'h1);
        txn(1'b1, 4'h6, 64'h100000, 3'b110);
        txn(1'b1, 4'h7, 64'h2FFFFF, 3'b110);
        txn(1'b1, 4'hC, 64'h300000, 3'b000);
        txn(1'b1, 4'hE, 64'hFFFFF, 3'b000);
        txn(1'b0, 4'hF, 64'h100000, 3'b010);
        txn(1'b0, 4'h6, 64'h300000, 3'b100);
        txn(1'b1, 4'h2, 64'h100000, 3'b000);
        txn(1'b1, 4'h6, 64'h100100000, 3'b000);
        txn(1'b1, 4'h7, 64'h110000000, 3'b101);
        txn(1'b1, 4'h6, 64'h1100FFFFF, 3'b101);
        txn(1'b1, 4'h6, 64'h110100000, 3'b000);
        txn(1'b1, 4'hC, 64'h10FFFFFFF, 3'b000);
        txn(1'b1, 4'hE, 64'h10000000, 3'b000);
        txn(1'b0, 4'h7, 64'h110000000, 3'b001);
        wr(8'h20, 4'h0, 32'h00100020);
        txn(1'b1, 4'h6, 64'h100000, 3'b000);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(8'h20, 32'h0);
        rd(8'h24, 32'h00010001);
        rd(8'h28, 32'h0);
        txn(1'b1, 4'h6, 64'h80000, 3'b111);
        wrap_up;
    end
endmodule // bmw_window_regs_tb_top
bind bmw_window_regs bmw_regs_asserts chk (.clk_sys(clk_sys), .arst_n(arst_n), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q),
    .cfg_hit_q(cfg_hit_q), .txn_valid(txn_valid), .txn_from_primary(txn_from_primary),
    .txn_cmd(txn_cmd), .txn_addr(txn_addr), .fwd_valid_q(fwd_valid_q), .fwd_q(fwd_q),
    .fwd_mem_hit_q(fwd_mem_hit_q), .fwd_pf_hit_q(fwd_pf_hit_q));
